// file: core/swc_stream.sv
// Sample width converter: combinational core, buffer and streaming top
//
// What this block does
// RQ1: Left alignment keeps input MSBs, modulo rounding.
// RQ2: Right alignment keeps input LSBs, modulo clamping.
// RQ3: Widening left-aligned pads zeros below LSB.
// RQ4: Widening right-aligned sign- or zero-extends upward.
// RQ5: Narrowing with round/clamp avoids wrap and bias.
// RQ6: Without round/clamp, plain wires that may wrap.
// RQ7: Convergent rounding, exact halves go to even.
// RQ8: Combinational variant holds no storage at all.
// RQ9: Stream ports use full valid/ready handshake.
// RQ10: Register option adds output stage and latency.
// RQ11: Input bus is samples times width, doubled complex.
// RQ12: Output bus is samples times width, doubled complex.
// RQ13: Stream ports carry per-sample user sideband bits.
// RQ14: Rounding, signedness, complexity chosen at build time.
// RQ15: Clamp unrepresentable values to output max or min.
// RQ16: Complex parts converted independently, positions kept.
// RQ17: Last marker and sideband follow data, same latency.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

// Per-sample converter, no storage, every option a parameter
module width_converter_comb #(
	parameter int NS     = 1,
	parameter int IW     = 16,
	parameter int OW     = 12,
	parameter bit SIGNED = 1'b1,
	parameter bit LEFT   = 1'b1,
	parameter bit ROUND  = 1'b1
) (
	input  wire logic [NS*IW-1:0] data_in,
	output logic      [NS*OW-1:0] data_out,
	output logic      [NS-1:0]    clamp_out
);
	// Largest and smallest codes of the output width
	localparam logic [OW-1:0] MAXV = SIGNED ? ({OW{1'b1}} >> 1) : {OW{1'b1}};
	localparam logic [OW-1:0] MINV = SIGNED ? ~MAXV : '0;

	// Each lane converts alone, so real and imaginary keep their slots
	for (genvar i = 0; i < NS; i++) begin : g_lane // see RQ16
		logic [IW-1:0] x;
		assign x = data_in[i*IW +: IW];
		if (OW >= IW) begin : g_wide
			if (LEFT) begin : g_l
				if (OW == IW) begin : g_eq
					assign data_out[i*OW +: OW] = x;
				end else begin : g_pad
					// Zeros fill below the kept MSBs
					assign data_out[i*OW +: OW] = {x, {(OW-IW){1'b0}}}; // see RQ3
				end
			end else begin : g_r
				// Upper bits copy the sign, or zero when unsigned
				assign data_out[i*OW +: OW] =
					OW'({{(OW){SIGNED & x[IW-1]}}, x}); // see RQ4
			end
			assign clamp_out[i] = 1'b0;
		end else if (!ROUND) begin : g_wire
			// Plain slicing, values may wrap or bias
			if (LEFT) begin : g_l
				assign data_out[i*OW +: OW] = x[IW-1 -: OW]; // see RQ6 RQ1
			end else begin : g_r
				assign data_out[i*OW +: OW] = x[OW-1:0]; // see RQ6 RQ2
			end
			assign clamp_out[i] = 1'b0;
		end else if (LEFT) begin : g_rnd
			localparam int D = IW - OW;
			localparam logic [D-1:0] HALF = D'(1) << (D-1);
			logic [OW-1:0] keep;
			logic [D-1:0]  frac;
			logic          up;
			logic [OW:0]   sum;
			logic          ovf;
			assign keep = x[IW-1:D]; // see RQ1
			assign frac = x[D-1:0];
			// Above half rounds up, exact half only when odd
			assign up = (frac > HALF) || (frac == HALF && keep[0]); // see RQ7
			assign sum = {SIGNED & keep[OW-1], keep} + {{OW{1'b0}}, up};
			// Only upward overflow is possible after a round up
			assign ovf = SIGNED ? (sum[OW] != sum[OW-1]) : sum[OW];
			assign data_out[i*OW +: OW] = ovf ? MAXV : sum[OW-1:0]; // see RQ15 RQ5
			assign clamp_out[i] = ovf;
		end else begin : g_clp
			logic fits;
			// Dropped high bits must all equal the kept sign bit when signed, and must all be zero when unsigned
			if (SIGNED) begin : g_s
				assign fits = (x[IW-1:OW-1] == {(IW-OW+1){1'b0}}) ||
					(x[IW-1:OW-1] == {(IW-OW+1){1'b1}});
			end else begin : g_u
				assign fits = (x[IW-1:OW] == {(IW-OW){1'b0}});
			end
			assign data_out[i*OW +: OW] = fits ? x[OW-1:0] : // see RQ2
				((SIGNED && x[IW-1]) ? MINV : MAXV); // see RQ15 RQ5
			assign clamp_out[i] = ~fits;
		end
	end
endmodule

// Flip-flop FIFO with valid/ready on both sides
module swc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32,
	parameter int LW    = 6
) (
	input  wire logic          clk_in,
	input  wire logic          rstn_in,
	input  wire logic          in_valid_in,
	output logic               in_ready_out,
	input  wire logic [W-1:0]  in_data_in,
	output logic               out_valid_out,
	input  wire logic          out_ready_in,
	output logic      [W-1:0]  out_data_out,
	output logic      [LW-1:0] level_out
);
	localparam int AW = $clog2(DEPTH);

	// Whole state of the buffer
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;   // Storage words
		logic [AW-1:0]           wptr;  // Next write slot
		logic [AW-1:0]           rptr;  // Oldest word
		logic [LW-1:0]           level; // Words held
	} swc_fifo_s;

	swc_fifo_s st_q;
	swc_fifo_s st_d;
	logic      push;
	logic      pop;

	// Full and empty come straight from the level, never guessed
	assign in_ready_out  = (st_q.level != LW'(DEPTH)); // see RQ9
	assign out_valid_out = (st_q.level != '0);
	assign out_data_out  = st_q.mem[st_q.rptr];
	assign level_out     = st_q.level;
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	// Next state of pointers, level and storage
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wptr] = in_data_in;
			st_d.wptr = st_q.wptr + 1'b1;
		end
		if (pop) begin
			st_d.rptr = st_q.rptr + 1'b1;
		end
		// Simultaneous push and pop leave the level alone
		case ({push, pop})
			2'b10:   st_d.level = st_q.level + 1'b1;
			2'b01:   st_d.level = st_q.level - 1'b1;
			default: st_d.level = st_q.level;
		endcase
	end

	// State register
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// Streaming converter with register port and input buffer
module width_converter_streaming
	import swc_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  din_tvalid_in,
	output logic                       din_tready_out,
	input  wire logic [DIN_W-1:0]      din_tdata_in,
	input  wire logic [TUSER_W-1:0]    din_tuser_in,
	input  wire logic                  din_tlast_in,
	output logic                       dout_tvalid_out,
	input  wire logic                  dout_tready_in,
	output logic      [DOUT_W-1:0]     dout_tdata_out,
	output logic      [TUSER_W-1:0]    dout_tuser_out,
	output logic                       dout_tlast_out,
	input  wire logic [ADDR_W-1:0]     reg_addr_in,
	input  wire logic [DATA_W-1:0]     reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic      [DATA_W-1:0]     reg_rdata_out
);
	import swc_pkg::*;

	// Reset release synchroniser
	typedef struct packed {
		logic meta;   // First stage, read only by the second
		logic sync;   // Reset copy for the block
	} swc_rst_s;

	// Whole state of the top
	typedef struct packed {
		logic               ctrl_en;    // Software enable of input side
		logic               clamp_seen; // Sticky clamp flag
		logic [DATA_W-1:0]  beats;      // Output beats delivered
		logic [DATA_W-1:0]  rdata;      // Read data, one cycle late
		logic               ovalid;     // Output stage full
		swc_out_beat_s      obeat;      // Output stage contents
	} swc_top_s;

	swc_rst_s      rs_q;
	logic          rst_n;
	swc_top_s      st_q;
	swc_top_s      st_d;
	swc_in_beat_s  in_beat;           // Beat into the buffer
	swc_in_beat_s  buf_beat;          // Beat out of the buffer
	swc_out_beat_s conv_beat;         // Converted beat
	swc_reg_req_s  req;               // Register port request
	logic          buf_in_ready;
	logic          buf_valid;
	logic          buf_ready;
	logic [LEVEL_W-1:0] level;
	logic [NSAMP-1:0]   clamp;
	logic          out_fire;
	logic          buf_fire;

	// Reset is asserted at once and released after two edges
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rs_q <= '0;
		end else begin
			rs_q.meta <= 1'b1;
			rs_q.sync <= rs_q.meta;
		end
	end
	assign rst_n = rs_q.sync;

	// Bus widths follow samples, parts and sample width
	assign in_beat.data = din_tdata_in; // see RQ11
	assign in_beat.user = din_tuser_in; // see RQ13
	assign in_beat.last = din_tlast_in;
	assign req.wr    = reg_wr_in;
	assign req.rd    = reg_rd_in;
	assign req.addr  = reg_addr_in;
	assign req.wdata = reg_wdata_in;

	// Input is refused while software holds the block disabled
	assign din_tready_out = buf_in_ready && st_q.ctrl_en; // see RQ9

	// Buffer in the data path so upstream bursts ride over stalls
	swc_fifo #(
		.W     ($bits(swc_in_beat_s)),
		.DEPTH (FIFO_DEPTH),
		.LW    (LEVEL_W)
	) u_fifo (
		.clk_in        (clk_in),
		.rstn_in       (rst_n),
		.in_valid_in   (din_tvalid_in && st_q.ctrl_en),
		.in_ready_out  (buf_in_ready),
		.in_data_in    (in_beat),
		.out_valid_out (buf_valid),
		.out_ready_in  (buf_ready),
		.out_data_out  (buf_beat),
		.level_out     (level)
	);

	// Conversion itself has no state; choices are fixed at build
	width_converter_comb #(
		.NS     (NSAMP),
		.IW     (IN_WIDTH),
		.OW     (OUT_WIDTH),
		.SIGNED (IS_SIGNED),
		.LEFT   (JUST_LEFT),
		.ROUND  (ROUND_CLAMP)
	) u_conv ( // see RQ14 RQ8
		.data_in   (buf_beat.data),
		.data_out  (conv_beat.data),
		.clamp_out (clamp)
	);
	// Sideband rides with its sample unchanged
	assign conv_beat.user = buf_beat.user; // see RQ17 RQ13
	assign conv_beat.last = buf_beat.last; // see RQ17

	// With a stage the buffer drains when it is empty or moving
	assign buf_ready = PIPE ? (!st_q.ovalid || dout_tready_in)
	                        : dout_tready_in; // see RQ10
	assign buf_fire  = buf_valid && buf_ready;

	// Output comes from the stage or straight from the converter
	always_comb begin
		if (PIPE) begin // see RQ10
			dout_tvalid_out = st_q.ovalid;
			dout_tdata_out  = st_q.obeat.data; // see RQ12
			dout_tuser_out  = st_q.obeat.user;
			dout_tlast_out  = st_q.obeat.last;
		end else begin // see RQ6
			dout_tvalid_out = buf_valid;
			dout_tdata_out  = conv_beat.data;
			dout_tuser_out  = conv_beat.user;
			dout_tlast_out  = conv_beat.last;
		end
	end
	assign out_fire      = dout_tvalid_out && dout_tready_in;
	assign reg_rdata_out = st_q.rdata;

	// Next state: output stage, counters and registers
	always_comb begin
		st_d = st_q;
		st_d.rdata = '0;
		// Stage loads whenever the buffer hands over a beat
		if (buf_fire) begin
			st_d.obeat = conv_beat; // see RQ17
		end
		if (buf_fire) begin
			st_d.ovalid = 1'b1;
		end else if (dout_tready_in) begin
			st_d.ovalid = 1'b0;
		end
		if (out_fire) begin
			st_d.beats = st_q.beats + 1'b1;
		end
		// Writes; a clamp in the same cycle beats the clear
		if (req.wr) begin
			case (req.addr)
				CTRL_OFS: st_d.ctrl_en = req.wdata[CTRL_EN_BIT];
				STATUS_OFS: begin
					if (req.wdata[STAT_CLAMP_BIT]) begin
						st_d.clamp_seen = 1'b0;
					end
				end
				COUNT_OFS: st_d.beats = '0;
				default:   st_d.ctrl_en = st_q.ctrl_en;
			endcase
		end
		if (buf_fire && (clamp != '0)) begin // see RQ15
			st_d.clamp_seen = 1'b1;
		end
		// Reads answer next cycle, unmapped reads as zero
		if (req.rd) begin
			case (req.addr)
				CTRL_OFS: st_d.rdata[CTRL_EN_BIT] = st_q.ctrl_en;
				STATUS_OFS: begin
					st_d.rdata[STAT_CLAMP_BIT]  = st_q.clamp_seen;
					st_d.rdata[STAT_OVALID_BIT] = dout_tvalid_out;
					st_d.rdata[STAT_LEVEL_LSB +: LEVEL_W] = level;
				end
				COUNT_OFS: st_d.rdata = st_q.beats;
				default:   st_d.rdata = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.ctrl_en <= CTRL_EN_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Helpers for the checks on the first lane
	logic [IN_WIDTH-1:0]  s0_in;
	logic [OUT_WIDTH-1:0] s0_out;
	assign s0_in  = buf_beat.data[IN_WIDTH-1:0];
	assign s0_out = conv_beat.data[OUT_WIDTH-1:0];

	// A stalled output beat holds its value until taken
	out_hold_a: assert property ( // see RQ9
		@(posedge clk_in) disable iff (!rst_n)
		dout_tvalid_out && !dout_tready_in |=>
			dout_tvalid_out && $stable(dout_tdata_out)
			&& $stable(dout_tlast_out))
		else $error("output beat changed while stalled");

	// Disabled block never offers ready upstream
	in_gate_a: assert property ( // see RQ9
		@(posedge clk_in) disable iff (!rst_n)
		!st_q.ctrl_en |-> !din_tready_out)
		else $error("ready raised while disabled");

	// A beat handed to the stage appears one cycle later
	stage_lat_a: assert property ( // see RQ10 RQ17
		@(posedge clk_in) disable iff (!rst_n)
		PIPE && buf_fire |=> dout_tvalid_out
			&& dout_tdata_out == $past(conv_beat.data)
			&& dout_tuser_out == $past(buf_beat.user)
			&& dout_tlast_out == $past(buf_beat.last))
		else $error("stage latency or sideband mismatch");

	// Unstaged path follows the buffer in the same cycle
	wire_path_a: assert property ( // see RQ6 RQ17
		@(posedge clk_in) disable iff (!rst_n)
		!PIPE |-> dout_tvalid_out == buf_valid
			&& dout_tlast_out == buf_beat.last)
		else $error("combinational path not transparent");

	// Left rounding keeps MSBs or steps them up by one
	keep_msb_a: assert property ( // see RQ1
		@(posedge clk_in) disable iff (!rst_n)
		JUST_LEFT && NARROW && buf_valid && !clamp[0] |->
			(s0_out == s0_in[IN_WIDTH-1 -: OUT_WIDTH]) ||
			(s0_out == s0_in[IN_WIDTH-1 -: OUT_WIDTH] + 1'b1))
		else $error("left alignment lost the MSBs");

	// An exact half lands on an even code unless the lane clamps
	round_even_a: assert property ( // see RQ7
		@(posedge clk_in) disable iff (!rst_n)
		JUST_LEFT && NARROW && ROUND_CLAMP && buf_valid && !clamp[0]
		&& s0_in[IN_WIDTH-OUT_WIDTH-1:0] ==
			(IN_WIDTH-OUT_WIDTH)'(1) << (IN_WIDTH-OUT_WIDTH-1)
		|-> !s0_out[0])
		else $error("half did not round to even");

	// A clamped lane shows a limit code of the output width
	clamp_lim_a: assert property ( // see RQ15 RQ5
		@(posedge clk_in) disable iff (!rst_n)
		buf_valid && clamp[0] |->
			(s0_out == (IS_SIGNED ? {1'b0, {(OUT_WIDTH-1){1'b1}}}
				: {OUT_WIDTH{1'b1}})) ||
			(IS_SIGNED && s0_out == {1'b1, {(OUT_WIDTH-1){1'b0}}}))
		else $error("clamped lane not at a limit");

	// Sticky clamp flag is set by the cycle after a clamped beat
	clamp_flag_a: assert property ( // see RQ15
		@(posedge clk_in) disable iff (!rst_n)
		buf_fire && clamp != '0 |=> st_q.clamp_seen)
		else $error("clamp flag missed an event");

	// Count register reads back the beat count one cycle later
	count_rd_a: assert property ( // see RQ17
		@(posedge clk_in) disable iff (!rst_n)
		req.rd && req.addr == COUNT_OFS |=>
			reg_rdata_out == $past(st_q.beats))
		else $error("count read data wrong");
endmodule

// file: shared/swc_pkg.sv
// Package of constants and carrier types for the sample width converter
package swc_pkg;

	// Build-time shape of the stream
	localparam int SUPERSAMPLE = 2;           // Samples per clock
	localparam int IN_WIDTH    = 16;          // Bits per input sample
	localparam int OUT_WIDTH   = 12;          // Bits per output sample
	localparam int TUSER_WIDTH = 1;           // Sideband bits per sample
	localparam bit IS_COMPLEX  = 1'b1;        // Real and imaginary parts
	localparam bit IS_SIGNED   = 1'b1;        // Two's complement samples
	localparam bit JUST_LEFT   = 1'b1;        // 1 keeps MSBs, 0 keeps LSBs
	localparam bit ROUND_CLAMP = 1'b1;        // Round and clamp on narrowing
	localparam bit OUT_REG     = 1'b0;        // Extra output register stage

	// Derived bus widths
	localparam int PARTS    = IS_COMPLEX ? 2 : 1;
	localparam int NSAMP    = PARTS * SUPERSAMPLE;
	localparam int DIN_W    = NSAMP * IN_WIDTH;
	localparam int DOUT_W   = NSAMP * OUT_WIDTH;
	localparam int TUSER_W  = SUPERSAMPLE * TUSER_WIDTH;
	localparam bit NARROW   = OUT_WIDTH < IN_WIDTH;
	localparam bit PIPE     = OUT_REG || (ROUND_CLAMP && NARROW);

	// Buffer shape
	localparam int FIFO_DEPTH = 32;
	localparam int LEVEL_W    = 6;

	// Register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] COUNT_OFS  = 4'h8;
	localparam int CTRL_EN_BIT      = 0;      // Input acceptance enable
	localparam int STAT_CLAMP_BIT   = 0;      // Sticky clamp seen
	localparam int STAT_OVALID_BIT  = 1;      // Output holds a beat
	localparam int STAT_LEVEL_LSB   = 8;      // Buffer level field
	localparam logic CTRL_EN_RESET  = 1'b1;

	// Beat entering the block
	typedef struct packed {
		logic               last;
		logic [TUSER_W-1:0] user;
		logic [DIN_W-1:0]   data;
	} swc_in_beat_s;

	// Beat leaving the block
	typedef struct packed {
		logic               last;
		logic [TUSER_W-1:0] user;
		logic [DOUT_W-1:0]  data;
	} swc_out_beat_s;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} swc_reg_req_s;

endpackage

// file: verif/swc_sink.sv
// Downstream stream sink model with selectable stall pattern
`timescale 1ns/10ps
module swc_sink (
	input  wire logic                        clk_in,
	input  wire logic                        rstn_in,
	input  wire logic [1:0]                  mode_in,
	input  wire logic                        tvalid_in,
	output logic                             tready_out,
	input  wire logic [swc_pkg::DOUT_W-1:0]  tdata_in,
	input  wire logic [swc_pkg::TUSER_W-1:0] tuser_in,
	input  wire logic                        tlast_in,
	output int                               hold_err_out
);
	import swc_pkg::*;
	swc_out_beat_s got[$];  // Beats taken, in arrival order
	swc_out_beat_s held;    // Beat on the bus at the last edge
	logic          stalled; // Last edge saw valid without ready
	logic          tog;     // Phase of the alternating stall

	// Ready moves only after an edge; a stalled beat must not change
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tready_out   <= 1'b0;
			stalled      <= 1'b0;
			tog          <= 1'b0;
			hold_err_out <= 0;
		end else begin
			// Offered beat withdrawn or altered while stalled
			if (stalled && (!tvalid_in ||
			    {tlast_in, tuser_in, tdata_in} !== held))
				hold_err_out <= hold_err_out + 1;
			// Sideband and marker are kept with their data
			if (tvalid_in && tready_out)
				got.push_back({tlast_in, tuser_in, tdata_in});
			stalled <= tvalid_in && !tready_out;
			held    <= {tlast_in, tuser_in, tdata_in};
			tog     <= !tog;
			// Mode 0 always ready, 1 every other cycle, 2 stalled
			tready_out <= (mode_in == 2'd0) || (mode_in == 2'd1 && tog);
		end
	end
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the streaming width converter
`timescale 1ns/10ps
module tb_top;
	import swc_pkg::*;
	localparam int D = IN_WIDTH - OUT_WIDTH; // Dropped bits per lane
	logic               clk_in, rstn_in;     // Clock and reset
	logic               din_tvalid, din_tready;
	logic               dout_tvalid, dout_tready, dout_tlast;
	swc_in_beat_s       din;                 // Upstream beat on the bus
	logic [DOUT_W-1:0]  dout_tdata;
	logic [TUSER_W-1:0] dout_tuser;
	logic [ADDR_W-1:0]  reg_addr;
	logic [DATA_W-1:0]  reg_wdata, reg_rdata, v;
	logic               reg_wr, reg_rd;
	logic [1:0]         sink_mode;           // Downstream stall pattern
	int                 hold_err, errors, cmp_count;
	swc_out_beat_s      exp_q[$];            // Expected output beats

	width_converter_streaming dut_u (
		.clk_in(clk_in), .rstn_in(rstn_in),
		.din_tvalid_in(din_tvalid), .din_tready_out(din_tready),
		.din_tdata_in(din.data), .din_tuser_in(din.user),
		.din_tlast_in(din.last),
		.dout_tvalid_out(dout_tvalid), .dout_tready_in(dout_tready),
		.dout_tdata_out(dout_tdata), .dout_tuser_out(dout_tuser),
		.dout_tlast_out(dout_tlast),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata));

	swc_sink sink_u (
		.clk_in(clk_in), .rstn_in(rstn_in), .mode_in(sink_mode),
		.tvalid_in(dout_tvalid), .tready_out(dout_tready),
		.tdata_in(dout_tdata), .tuser_in(dout_tuser),
		.tlast_in(dout_tlast), .hold_err_out(hold_err));

	// 40 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = !clk_in;
	end

	// Compare and count; unknowns must match bit for bit
	task automatic chk(input logic [63:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: %s seen %h expected %h",
				$time, what, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One-cycle write strobe; data lines show garbage afterwards
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Convergent rounding of one lane, clamped at positive full scale
	function automatic logic [OUT_WIDTH-1:0] cv(input logic [15:0] x);
		logic signed [OUT_WIDTH:0] k;
		k = $signed(x[IN_WIDTH-1:D]);
		if (x[D-1:0] > (1 << (D-1)) ||
		    (x[D-1:0] == (1 << (D-1)) && k[0]))
			k = k + 1'b1;
		if (k > $signed((1 << (OUT_WIDTH-1)) - 1))
			k = (1 << (OUT_WIDTH-1)) - 1;
		return k[OUT_WIDTH-1:0];
	endfunction

	// Expected beat: lanes converted in place, sideband unchanged
	function automatic swc_out_beat_s mk(input swc_in_beat_s b);
		mk.last = b.last;
		mk.user = b.user;
		for (int i = 0; i < NSAMP; i++)
			mk.data[i*OUT_WIDTH +: OUT_WIDTH] = cv(b.data[i*IN_WIDTH +: 16]);
	endfunction

	// Offer a beat (called at an edge); valid stays up after the take
	task automatic send(input swc_in_beat_s b, input int bound,
		output bit ok);
		din_tvalid <= 1'b1;
		din        <= b;
		ok = 1'b0;
		for (int i = 0; i < bound && !ok; i++) begin
			@(posedge clk_in);
			ok = din_tready;
		end
		if (ok)
			exp_q.push_back(mk(b));
		else if (bound > 50) begin
			errors++;
			$display("MISMATCH at %0t: input never accepted", $time);
			final_report();
		end
	endtask

	// Release the input; data lines show the inverse of the last beat
	task automatic idle;
		din_tvalid <= 1'b0;
		din        <= ~din;
	endtask

	// Wait for all expected beats, then compare them in order
	task automatic drain;
		for (int i = 0; i < 2000 && sink_u.got.size() < exp_q.size(); i++)
			@(posedge clk_in);
		chk(sink_u.got.size(), exp_q.size(), "beat count");
		if (sink_u.got.size() != exp_q.size())
			final_report();
		foreach (exp_q[i])
			chk(64'(sink_u.got[i]), 64'(exp_q[i]), "beat");
		sink_u.got.delete();
		exp_q.delete();
	endtask

	// Reset values, unmapped read, input enable
	task automatic t_regs;
		rd(CTRL_OFS, v);
		chk(v, 32'(CTRL_EN_RESET) << CTRL_EN_BIT, "ctrl reset");
		rd(4'hC, v);
		chk(v, 64'h0000_0000, "unmapped read");
		rd(COUNT_OFS, v);
		chk(v, 64'h0000_0000, "count reset");
		wr(CTRL_OFS, 32'h0000_0000);
		#1 chk(din_tready, 1'b0, "ready while disabled");
		wr(CTRL_OFS, 32'h0000_0001);
		#1 chk(din_tready, 1'b1, "ready when enabled");
		$display("test regs done");
	endtask

	// Rounding cases: below, above, ties both ways, negative, overflow
	task automatic t_round;
		logic [15:0]  x[8] = '{16'h0123, 16'h012C, 16'h0128, 16'h0138,
		                       16'hFFF8, 16'h8000, 16'h7FF8, 16'h7FF7};
		swc_in_beat_s b;
		bit           ok;
		sink_mode <= 2'd0;
		@(posedge clk_in);
		for (int n = 0; n < 2; n++) begin
			for (int i = 0; i < NSAMP; i++)
				b.data[i*IN_WIDTH +: 16] = x[n*NSAMP + i];
			b.user = TUSER_W'(n + 1);
			b.last = (n == 1);
			send(b, 100, ok);
		end
		idle();
		drain();
		rd(STATUS_OFS, v);
		chk(v[STAT_CLAMP_BIT], 1'b1, "clamp seen");
		wr(STATUS_OFS, 32'h0000_0001 << STAT_CLAMP_BIT);
		rd(STATUS_OFS, v);
		chk(v[STAT_CLAMP_BIT], 1'b0, "clamp cleared");
		rd(COUNT_OFS, v);
		chk(v, 64'h0000_0002, "beats delivered");
		wr(COUNT_OFS, 32'h0000_0000);
		rd(COUNT_OFS, v);
		chk(v, 64'h0000_0000, "count cleared");
		$display("test round done");
	endtask

	// Fill the buffer against a stalled sink, then drain with stalls
	task automatic t_fill;
		swc_in_beat_s b;
		bit           ok;
		int           n;
		sink_mode <= 2'd2;
		repeat (2) @(posedge clk_in);
		n  = 0;
		ok = 1'b1;
		while (ok && n < 40) begin
			b.data = {NSAMP{16'(n * 16'h0931 + 16'h0005)}};
			b.user = TUSER_W'(n);
			b.last = n[2];
			send(b, 20, ok);
			n += int'(ok);
		end
		chk(n, FIFO_DEPTH + int'(PIPE), "beats until refused");
		rd(STATUS_OFS, v);
		chk(v[STAT_LEVEL_LSB +: LEVEL_W], FIFO_DEPTH, "full level");
		chk(v[STAT_OVALID_BIT], 1'b1, "output holds a beat");
		chk(din_tready, 1'b0, "ready while full");
		sink_mode <= 2'd1;
		send(b, 500, ok);
		idle();
		drain();
		rd(STATUS_OFS, v);
		chk(v[STAT_LEVEL_LSB +: LEVEL_W], 0, "empty level");
		rd(COUNT_OFS, v);
		chk(v, n + 1, "beats after drain");
		$display("test fill done");
	endtask

	// Main sequence
	initial begin
		rstn_in    = 1'b0;
		din_tvalid = 1'b0;
		din        = '0;
		reg_addr   = '0;
		reg_wdata  = '0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		sink_mode  = 2'd0;
		errors     = 0;
		cmp_count  = 0;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_regs();
		t_round();
		t_fill();
		chk(hold_err, 0, "stalled beat held");
		final_report();
	end
endmodule
